// File: rtl/pixel_lookup_pkg.sv
// constants, types and register map of the pixel lookup table mapper
`default_nettype none
package pixel_lookup_pkg;
  // table geometry
  localparam int IDX_W      = 11;
  localparam int VAL_W      = 9;
  localparam int ENTRIES    = 2048;
  localparam logic [10:0] IDX_MAX = 11'h7ff;
  localparam int PIX_IN_W   = 16;
  localparam int CHANNELS   = 3;
  localparam int FIFO_DEPTH = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SEL    = 8'h04;
  localparam logic [7:0] OFS_INDEX  = 8'h08;
  localparam logic [7:0] OFS_VALUE  = 8'h0c;
  localparam logic [7:0] OFS_BULK   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // control field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_FMT_LSB = 1;
  localparam int CTRL_RGB_BIT = 3;
  // reset values
  localparam logic       RST_ENABLE = 1'b0;
  localparam logic [1:0] RST_FMT    = 2'h0;
  localparam logic [1:0] SEL_USER_ONE = 2'h0;
  // low zero bits added for wide formats
  localparam int PAD12 = 3;
  localparam int PAD16 = 7;

  typedef enum logic [1:0] {FMT_8, FMT_12, FMT_16} out_fmt_t;

  // pixel word on the way in and out
  typedef struct packed {
    logic [CHANNELS-1:0][PIX_IN_W-1:0] ch;
  } pix_in_t;
  typedef struct packed {
    logic [CHANNELS-1:0][15:0] ch;
  } pix_out_t;

  // ahb-lite slave side signals from the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;
endpackage
`default_nettype wire

// File: rtl/pixel_lookup_table.sv
// pixel lookup table mapper with ahb-lite registers and input fifo
// register map, one aligned 32-bit word each
// 0x00 control: bit 0 table enable, bits 2:1 format, bit 3 three channels
// 0x04 table selector: only code 0, the user table, is kept
// 0x08 entry index: 11 bits, a wider value leaves it unchanged
// 0x0c entry value: coefficient at the entry index, bits 8:0
// 0x10 bulk coefficients: one coefficient per access, pointer steps
// 0x14 status: bits 10:0 bulk pointer, bit 16 default load busy
// other offsets read as zero and drop writes
//
// format codes
// 0 gives 8-bit words, the table result loses its lsb
// 1 gives 12-bit words, three zero bits below the result
// 2 and 3 give 16-bit words, seven zero bits below the result
// with the table off the clamped value is shifted to fit instead
//
// bus timing
// zero wait states, the response is always okay
// read data stands only in the data phase cycle
// back to back transfers need no idle cycle between them
// an index write also rewinds the bulk pointer to entry 0
// the bulk pointer wraps after the last entry
//
// pixel timing
// channel 0 in bits 15:0, channel 1 in 31:16, channel 2 in 47:32
// mono and bayer use channel 0 only, the other two read zero
// values above 2047 saturate before the lookup or the bypass
// the first mapped word leaves one edge after the input is taken
// one word per cycle sustained, the output holds while stalled
// the fifo fills during the default load but nothing leaves it
//
// reset and default load
// asynchronous and active low, every register clears except the default load busy flag, which sets
// after release 2048 cycles write each entry with its index over four
// coefficient and bulk writes during the load are dropped
// the bulk pointer still steps on those dropped writes
//
// hazards for software
// coefficient edits go live at once, clear the enable first
// format and enable changes act on the next word staged
// the table is volatile, every reset reloads the linear default
// the selector reads zero whatever was written to it
`timescale 1ns/100ps
`default_nettype none

module pixel_lookup_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_st_t;

  fifo_st_t         st_r;
  fifo_st_t         st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // honest full and empty from pointer comparison
  assign empty     = (st_r.wr == st_r.rd);
  assign full      = (st_r.wr[AW] != st_r.rd[AW]) && (st_r.wr[AW-1:0] == st_r.rd[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[st_r.rd[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  // pointer update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end

  // pointers held in flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem[st_r.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

module pixel_lookup_table
  import pixel_lookup_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic     clock,
  input  wire logic     rst_n,
  // register bus
  input  wire ahb_req_t bus_req,
  output ahb_rsp_t      bus_rsp,
  // upstream pixels
  input  wire logic     pix_in_valid,
  output logic          pix_in_ready,
  input  wire pix_in_t  pix_in,
  // downstream pixels
  output logic          pix_out_valid,
  input  wire logic     pix_out_ready,
  output pix_out_t      pix_out
);
  typedef struct packed {
    logic        ph_act;     // data phase pending
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic        enable;
    logic [1:0]  fmt;
    logic        rgb;
    logic [1:0]  selector;
    logic [10:0] index;
    logic [10:0] bulk_ptr;
    logic        init_busy;
    logic [10:0] init_ptr;
    logic        out_valid;
    pix_out_t    out;
  } state_t;

  state_t             st_r;
  state_t             st_nxt;
  logic [VAL_W-1:0]   table_mem [ENTRIES];
  logic               tbl_we;
  logic [IDX_W-1:0]   tbl_wa;
  logic [VAL_W-1:0]   tbl_wd;
  logic               f_valid;
  logic               f_ready;
  pix_in_t            f_data;
  logic               advance;
  logic               addr_phase;
  logic [31:0]        rd_word;

  // clamp one raw value to eleven bits
  function automatic logic [10:0] clamp11(input logic [PIX_IN_W-1:0] v);
    if (v > PIX_IN_W'(IDX_MAX)) begin
      return IDX_MAX;
    end
    return v[10:0];
  endfunction

  // fit a nine-bit table result into the output format
  function automatic logic [15:0] fit9(input logic [8:0] t, input logic [1:0] f);
    case (out_fmt_t'(f))
      FMT_8:   return {8'h00, t[8:1]};
      FMT_12:  return {4'h0, t, {PAD12{1'b0}}};
      default: return {t, {PAD16{1'b0}}};
    endcase
  endfunction

  // fit a clamped eleven-bit value without the table
  function automatic logic [15:0] fit11(input logic [10:0] v, input logic [1:0] f);
    case (out_fmt_t'(f))
      FMT_8:   return {8'h00, v[10:3]};
      FMT_12:  return {4'h0, v, 1'b0};
      default: return {v, 5'h00};
    endcase
  endfunction

  // fifo on the incoming pixel path, held off while the table loads
  pixel_lookup_fifo #(
    .WIDTH (CHANNELS * PIX_IN_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (pix_in_valid),
    .in_ready  (pix_in_ready),
    .in_data   (pix_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // output stage frees when empty or taken downstream
  assign advance       = !st_r.out_valid || pix_out_ready;
  assign f_ready       = advance && !st_r.init_busy;
  assign pix_out_valid = st_r.out_valid;
  assign pix_out       = st_r.out;

  // address phase taken when selected, nonseq or seq, bus ready
  assign addr_phase = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;

  // read mux for the data phase
  always_comb begin
    rd_word = 32'h0000_0000;
    if (st_r.ph_addr == OFS_CTRL) begin
      rd_word[CTRL_EN_BIT]                  = st_r.enable;
      rd_word[CTRL_FMT_LSB +: 2]            = st_r.fmt;
      rd_word[CTRL_RGB_BIT]                 = st_r.rgb;
    end else if (st_r.ph_addr == OFS_SEL) begin
      rd_word[1:0] = st_r.selector;
    end else if (st_r.ph_addr == OFS_INDEX) begin
      rd_word[10:0] = st_r.index;
    end else if (st_r.ph_addr == OFS_VALUE) begin
      rd_word[8:0] = table_mem[st_r.index];
    end else if (st_r.ph_addr == OFS_BULK) begin
      rd_word[8:0] = table_mem[st_r.bulk_ptr];
    end else if (st_r.ph_addr == OFS_STATUS) begin
      rd_word[10:0] = st_r.bulk_ptr;
      rd_word[16]   = st_r.init_busy;
    end
  end

  // zero wait, always okay, data only in a read data phase
  assign bus_rsp.hrdata    = (st_r.ph_act && !st_r.ph_write) ? rd_word : 32'h0000_0000;
  assign bus_rsp.hreadyout = 1'b1;
  assign bus_rsp.hresp     = 1'b0;

  // next state: bus, default load, pixel mapping
  always_comb begin
    logic [10:0] v;
    logic [1:0]  nch;
    st_nxt = st_r;
    tbl_we = 1'b0;
    tbl_wa = '0;
    tbl_wd = '0;
    v      = '0;
    nch    = '0;

    // address phase capture
    st_nxt.ph_act = addr_phase;
    if (addr_phase) begin
      st_nxt.ph_write = bus_req.hwrite;
      st_nxt.ph_addr  = bus_req.haddr[7:0];
    end

    if (st_r.init_busy) begin
      tbl_we          = 1'b1;
      tbl_wa          = st_r.init_ptr;
      tbl_wd          = st_r.init_ptr[10:2];
      st_nxt.init_ptr = st_r.init_ptr + 11'h001;
      if (st_r.init_ptr == IDX_MAX) begin
        st_nxt.init_busy = 1'b0;
      end
    end

    // data phase writes
    if (st_r.ph_act && st_r.ph_write) begin
      if (st_r.ph_addr == OFS_CTRL) begin
        st_nxt.enable = bus_req.hwdata[CTRL_EN_BIT];
        st_nxt.fmt    = bus_req.hwdata[CTRL_FMT_LSB +: 2];
        st_nxt.rgb    = bus_req.hwdata[CTRL_RGB_BIT];
      end else if (st_r.ph_addr == OFS_SEL) begin
        // only the single user table is selectable
        if (bus_req.hwdata[1:0] == SEL_USER_ONE) begin
          st_nxt.selector = SEL_USER_ONE;
        end
      end else if (st_r.ph_addr == OFS_INDEX) begin
        if (bus_req.hwdata[31:11] == 21'h00_0000) begin
          st_nxt.index = bus_req.hwdata[10:0];
        end
        st_nxt.bulk_ptr = 11'h000;
      end else if (st_r.ph_addr == OFS_VALUE) begin
        if (!st_r.init_busy) begin
          tbl_we = 1'b1;
          tbl_wa = st_r.index;
          tbl_wd = bus_req.hwdata[8:0];
        end
      end else if (st_r.ph_addr == OFS_BULK) begin
        // bulk write steps its own pointer
        if (!st_r.init_busy) begin
          tbl_we = 1'b1;
          tbl_wa = st_r.bulk_ptr;
          tbl_wd = bus_req.hwdata[8:0];
        end
        st_nxt.bulk_ptr = st_r.bulk_ptr + 11'h001;
      end
    end else if (st_r.ph_act && st_r.ph_addr == OFS_BULK) begin
      st_nxt.bulk_ptr = st_r.bulk_ptr + 11'h001;
    end

    // pixel mapping into the output stage
    if (advance) begin
      st_nxt.out_valid = f_valid && !st_r.init_busy;
      if (f_valid && !st_r.init_busy) begin
        nch = st_r.rgb ? 2'(CHANNELS) : 2'd1;
        for (int c = 0; c < CHANNELS; c++) begin
          v = clamp11(f_data.ch[c]);
          if (2'(c) >= nch) begin
            st_nxt.out.ch[c] = 16'h0000;
          end else if (st_r.enable) begin
            st_nxt.out.ch[c] = fit9(table_mem[v], st_r.fmt);
          end else begin
            st_nxt.out.ch[c] = fit11(v, st_r.fmt);
          end
        end
      end
    end
  end

  // state registers, reset to defaults
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.enable    <= RST_ENABLE;
      st_r.fmt       <= RST_FMT;
      st_r.selector  <= SEL_USER_ONE;
      st_r.init_busy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // table storage, volatile
  always_ff @(posedge clock) begin
    if (tbl_we) begin
      table_mem[tbl_wa] <= tbl_wd;
    end
  end
endmodule

`default_nettype wire

// File: bench/pixel_lookup_properties.sv
// port assertions for the lookup table mapper
`timescale 1ns/100ps
`default_nettype none
module pixel_lookup_checker
  import pixel_lookup_pkg::*;
(
  // clock and reset
  input wire logic     clock,
  input wire logic     rst_n,
  // register bus
  input wire ahb_req_t bus_req,
  input wire ahb_rsp_t bus_rsp,
  // pixels
  input wire logic     pix_in_valid,
  input wire logic     pix_in_ready,
  input wire pix_in_t  pix_in,
  input wire logic     pix_out_valid,
  input wire logic     pix_out_ready,
  input wire pix_out_t pix_out
);
  logic        acc;
  logic [11:0] up_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // any bus transfer taken
  assign acc = bus_req.hsel & bus_req.htrans[1] & bus_req.hready;
  // cycles since reset, saturating at 2048
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      up_r <= '0;
    else if (!up_r[11])
      up_r <= up_r + 12'h001;
  end
  // read address phase at one offset
  sequence s_rd(ofs);
    acc && !bus_req.hwrite && bus_req.haddr == {24'h00_0000, ofs};
  endsequence
  a_resp_okay: assert property (!bus_rsp.hresp && bus_rsp.hreadyout) else $error("bad response");
  a_rdata_idle: assert property (!acc |=> bus_rsp.hrdata == 0) else $error("stray read data");
  a_coef_width: assert property (s_rd(OFS_VALUE) |=> bus_rsp.hrdata[31:9] == 0)
    else $error("coefficient too wide");
  a_bulk_width: assert property (s_rd(OFS_BULK) |=> bus_rsp.hrdata[31:9] == 0)
    else $error("bulk word too wide");
  a_index_width: assert property (s_rd(OFS_INDEX) |=> bus_rsp.hrdata[31:11] == 0)
    else $error("index too wide");
  a_sel_single: assert property (s_rd(OFS_SEL) |=> bus_rsp.hrdata == 0)
    else $error("selector not user table");
  a_unmapped_zero: assert property (s_rd(8'h18) |=> bus_rsp.hrdata == 0) else $error("unmapped read");
  a_out_hold: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out))
    else $error("output dropped while stalled");
  a_width_shape: assert property (pix_out_valid |->
    (pix_out.ch[0][15:8] == 0 || !pix_out.ch[0][0]) && (pix_out.ch[1][15:8] == 0 ||
    !pix_out.ch[1][0]) && (pix_out.ch[2][15:8] == 0 || !pix_out.ch[2][0])) else $error("bad width");
  a_load_wait: assert property (!up_r[11] |-> !pix_out_valid)
    else $error("output before table load");
endmodule
bind pixel_lookup_table pixel_lookup_checker i_chk (.clock, .rst_n, .bus_req, .bus_rsp,
  .pix_in_valid, .pix_in_ready, .pix_in, .pix_out_valid, .pix_out_ready, .pix_out);
`default_nettype wire

// File: bench/pixel_source.sv
// upstream pixel source model
`timescale 1ns/100ps
`default_nettype none
module pixel_source
  import pixel_lookup_pkg::*;
(
  // clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // pixels to the mapper
  input  wire logic   pix_in_ready,
  output var logic    pix_in_valid,
  output var pix_in_t pix_in
);
  pix_in_t q [$];
  initial begin
    pix_in_valid = 1'b0;
    pix_in = '0;
  end
  task automatic push(input pix_in_t p);
    q.push_back(p);
  endtask
  // hold each word until taken, scramble data while idle
  always @(posedge clock) begin
    if (!rst_n) begin
      pix_in_valid <= 1'b0;
    end else if (!pix_in_valid || pix_in_ready) begin
      pix_in_valid <= q.size() > 0;
      pix_in <= (q.size() > 0) ? q.pop_front() : ~pix_in;
    end
  end
endmodule
`default_nettype wire

// File: bench/pixel_lookup_table_bench.sv
// self-checking bench of the lookup table mapper
`timescale 1ns/100ps
`default_nettype none
module pixel_lookup_table_bench
  import pixel_lookup_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        pix_out_ready = 1'b1;
  logic        pix_in_valid;
  logic        pix_in_ready;
  logic        pix_out_valid;
  ahb_req_t    req = '0;
  ahb_req_t    bus_req;
  ahb_rsp_t    bus_rsp;
  pix_in_t     pix_in;
  pix_out_t    pix_out;
  logic [8:0]  sh [ENTRIES];
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #10 clock = ~clock;
  always_comb begin
    bus_req = req;
    bus_req.hready = bus_rsp.hreadyout;
  end
  pixel_lookup_table #(.DEPTH(FIFO_DEPTH)) i_dut (.clock, .rst_n, .bus_req, .bus_rsp,
    .pix_in_valid, .pix_in_ready, .pix_in, .pix_out_valid, .pix_out_ready, .pix_out);
  pixel_source i_src (.clock, .rst_n, .pix_in_ready, .pix_in_valid, .pix_in);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= {24'h00_0000, a};
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge clock); while (bus_req.hready !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge clock); while (bus_req.hready !== 1'b1);
    rd = bus_rsp.hrdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  function automatic logic [15:0] mapv(input logic [15:0] p, input logic en, input logic [1:0] f);
    logic [10:0] v;
    v = (p > 16'h07ff) ? IDX_MAX : p[10:0];
    if (en)
      return (f == 0) ? {8'h00, sh[v][8:1]} : (f == 1) ? {4'h0, sh[v], 3'h0} : {sh[v], 7'h00};
    return (f == 0) ? {8'h00, v[10:3]} : (f == 1) ? {4'h0, v, 1'b0} : {v, 5'h00};
  endfunction
  task automatic take(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e2);
    do @(negedge clock); while (pix_out_valid !== 1'b1);
    chk("ch0", {16'h0000, e0}, {16'h0000, pix_out.ch[0]});
    chk("ch1", {16'h0000, e1}, {16'h0000, pix_out.ch[1]});
    chk("ch2", {16'h0000, e2}, {16'h0000, pix_out.ch[2]});
    @(posedge clock);
  endtask
  task automatic t_boot();
    ahb(1'b1, OFS_CTRL, 32'h0000_0005);
    i_src.push({32'h0000_0000, 16'h0400});
    take(16'h8000, 16'h0000, 16'h0000);
    rdc("status", OFS_STATUS, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      ahb(1'b1, OFS_INDEX, 32'h0000_07fd - 32'(i * 1021));
      rdc("default", OFS_VALUE, (32'h0000_07fd - 32'(i * 1021)) >> 2);
    end
  endtask
  task automatic t_regs();
    ahb(1'b1, OFS_SEL, 32'h0000_0001);
    rdc("selector", OFS_SEL, 32'h0000_0000);
    ahb(1'b1, OFS_INDEX, 32'h0000_0005);
    ahb(1'b1, OFS_INDEX, 32'h0000_0800);
    rdc("index", OFS_INDEX, 32'h0000_0005);
    ahb(1'b1, 8'h18, 32'hffff_ffff);
    rdc("unmapped", 8'h18, 32'h0000_0000);
    ahb(1'b1, OFS_CTRL, 32'h0000_0000);
    ahb(1'b1, OFS_VALUE, 32'hffff_fe1a);
    sh[5] = 9'h01a;
    rdc("value", OFS_VALUE, 32'h0000_001a);
  endtask
  task automatic t_bulk();
    ahb(1'b1, OFS_INDEX, 32'h0000_0000);
    for (int i = 1; i < 4; i++) begin
      ahb(1'b1, OFS_BULK, 32'(i * 17));
      sh[i - 1] = 9'(i * 17);
    end
    rdc("pointer", OFS_STATUS, 32'h0000_0003);
    ahb(1'b1, OFS_INDEX, 32'h0000_0001);
    rdc("bulk entry", OFS_VALUE, 32'h0000_0022);
    ahb(1'b1, OFS_INDEX, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      rdc("bulk read", OFS_BULK, {23'h00_0000, sh[i]});
  endtask
  task automatic t_map();
    logic [15:0] x [3];
    x = '{16'h0001, 16'h03e8, 16'hffff};
    for (int f = 0; f < 4; f++) begin
      for (int en = 0; en < 2; en++) begin
        ahb(1'b1, OFS_CTRL, {28'h000_0000, f[0], f[1:0], en[0]});
        i_src.push({x[2], x[1], x[0]});
        take(mapv(x[0], en[0], f[1:0]), f[0] ? mapv(x[1], en[0], f[1:0]) : 16'h0000,
          f[0] ? mapv(x[2], en[0], f[1:0]) : 16'h0000);
      end
    end
  endtask
  task automatic t_live();
    ahb(1'b1, OFS_CTRL, 32'h0000_0005);
    ahb(1'b1, OFS_INDEX, 32'h0000_0002);
    ahb(1'b1, OFS_VALUE, 32'h0000_00f0);
    sh[2] = 9'h0f0;
    i_src.push({32'h0000_0000, 16'h0002});
    take(16'h7800, 16'h0000, 16'h0000);
    pix_out_ready <= 1'b0;
    for (int i = 0; i < 18; i++)
      i_src.push({32'h0000_0000, 16'(i * 100)});
    repeat (40) @(negedge clock);
    chk("in_ready", 32'h0000_0000, {31'h0, pix_in_ready});
    @(posedge clock);
    pix_out_ready <= 1'b1;
    for (int i = 0; i < 18; i++)
      take(mapv(16'(i * 100), 1'b1, 2'h2), 16'h0000, 16'h0000);
    repeat (4) @(negedge clock);
    chk("out_valid", 32'h0000_0000, {31'h0, pix_out_valid});
    @(posedge clock);
  endtask
  // reset in mid-run, edited entry must come back as default
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rdc("busy", OFS_STATUS, 32'h0001_0000);
    do ahb(1'b0, OFS_STATUS, 32'h0000_0000); while (rd[16] !== 1'b0);
    rdc("ctrl after reset", OFS_CTRL, 32'h0000_0000);
    ahb(1'b1, OFS_INDEX, 32'h0000_0005);
    rdc("restored", OFS_VALUE, 32'h0000_0001);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    for (int i = 0; i < ENTRIES; i++)
      sh[i] = 9'(i / 4);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_boot();
    t_regs();
    t_bulk();
    t_map();
    t_live();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
